// file: include/regc_pkg.sv
// Package with the offsets, field layouts and reset values of the register bank.
package regc_pkg;
	// Register offsets in bytes, one aligned word each.
	localparam logic [7:0] REGC_CTRL_OFS = 8'h00;
	localparam logic [7:0] REGC_STATUS_OFS = 8'h04;
	localparam logic [7:0] REGC_CMD_OFS = 8'h08;
	localparam logic [7:0] REGC_FLAGS_SET_OFS = 8'h0C;
	localparam logic [7:0] REGC_FLAGS_CLR_OFS = 8'h10;
	localparam logic [7:0] REGC_DBGCTRL_OFS = 8'h14;
	// Control register fields.
	localparam int REGC_CTRL_EN_BIT = 0;
	localparam int REGC_CTRL_MODE_LSB = 2;
	localparam int REGC_CTRL_CFG_LSB = 4;
	localparam logic [31:0] REGC_CTRL_MASK = 32'h0000_00FD;
	localparam logic [31:0] REGC_CTRL_RST = 32'h0000_0000;
	localparam logic [1:0] REGC_MODE_RSVD = 2'h3;
	// Status register fields.
	localparam int REGC_STAT_STATE_LSB = 0;
	localparam int REGC_STAT_BUSY_BIT = 8;
	localparam logic [1:0] REGC_STATE_RSVD = 2'h3;
	localparam logic [1:0] REGC_STATE_TOP = 2'h2;
	localparam logic [31:0] REGC_STATUS_MASK = 32'h0000_0103;
	// Command register fields.
	localparam int REGC_CMD_START_BIT = 0;
	// Debug control register fields.
	localparam int REGC_DBG_HALT_BIT = 0;
	localparam logic [31:0] REGC_DBG_MASK = 32'h0000_0001;
	localparam logic [31:0] REGC_DBG_RST = 32'h0000_0000;
	localparam logic [31:0] REGC_FLAGS_RST = 32'h0000_0000;
endpackage

// file: core/regc_bank.sv
// Generic peripheral register bank with read-only, write-only, set/clear and debug registers.
`timescale 1ns/100ps
// What this block does
// - Writes to read-only bits are dropped with no effect; reads show live value.
// - Write-only bits take writes; their read value is meaningless to software.
// - Reserved bits always read as zero whatever was written.
// - A read-only field never shows a reserved encoding.
// - Power and software reset load reset values; debug control survives software reset.
// - A one written to the clear register clears the shared bit.
// - A one written to the set register sets the shared bit.
// - Both registers of a set/clear pair read the same shared value.
// - Set and clear of one bit in one cycle leaves it cleared.
module regc_bank #(
	parameter int FLAG_W = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic sw_reset,
	input wire logic a_wr,
	input wire logic [7:0] a_addr,
	input wire logic [31:0] a_wdata,
	input wire logic b_wr,
	input wire logic [7:0] b_addr,
	input wire logic [31:0] b_wdata,
	input wire logic rd_en,
	input wire logic [7:0] rd_addr,
	input wire logic [1:0] hw_state,
	input wire logic hw_busy,
	output logic [31:0] rdata,
	output logic rvalid,
	output logic ctrl_enable,
	output logic [1:0] ctrl_mode,
	output logic [3:0] ctrl_cfg,
	output logic [FLAG_W-1:0] flags,
	output logic dbg_halt,
	output logic cmd_start
);
	import regc_pkg::*;

	logic [31:0] ctrl_ff;
	logic [31:0] status_ff;
	logic [FLAG_W-1:0] flags_ff;
	logic [31:0] dbg_ff;
	logic cmd_start_ff;
	logic [31:0] rdata_ff;
	logic rvalid_ff;
	logic [7:0] rd_addr_ff;
	logic [31:0] nxt_ctrl;
	logic [FLAG_W-1:0] set_m;
	logic [FLAG_W-1:0] clr_m;
	logic [1:0] nxt_state;
	logic [31:0] nxt_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Write decode.

	// Port A wins a clash on the control register; a reserved mode keeps the old mode.
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (b_wr && b_addr == REGC_CTRL_OFS) begin
			nxt_ctrl = b_wdata & REGC_CTRL_MASK;
		end
		if (a_wr && a_addr == REGC_CTRL_OFS) begin
			nxt_ctrl = a_wdata & REGC_CTRL_MASK;
		end
		if (nxt_ctrl[REGC_CTRL_MODE_LSB +: 2] == REGC_MODE_RSVD) begin
			nxt_ctrl[REGC_CTRL_MODE_LSB +: 2] = ctrl_ff[REGC_CTRL_MODE_LSB +: 2];
		end
	end

	// Both ports may hit the pair at once, so set and clear masks merge across ports.
	always_comb begin
		set_m = '0;
		clr_m = '0;
		if (a_wr && a_addr == REGC_FLAGS_SET_OFS) begin
			set_m = set_m | a_wdata[FLAG_W-1:0];
		end
		if (b_wr && b_addr == REGC_FLAGS_SET_OFS) begin
			set_m = set_m | b_wdata[FLAG_W-1:0];
		end
		if (a_wr && a_addr == REGC_FLAGS_CLR_OFS) begin
			clr_m = clr_m | a_wdata[FLAG_W-1:0];
		end
		if (b_wr && b_addr == REGC_FLAGS_CLR_OFS) begin
			clr_m = clr_m | b_wdata[FLAG_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Storage.

	// Control register, reloaded by either reset.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_ff <= REGC_CTRL_RST;
		end else if (sw_reset) begin
			ctrl_ff <= REGC_CTRL_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Shared set/clear bits; clear is applied last so it beats a simultaneous set.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_ff <= REGC_FLAGS_RST[FLAG_W-1:0];
		end else if (sw_reset) begin
			flags_ff <= REGC_FLAGS_RST[FLAG_W-1:0];
		end else begin
			flags_ff <= (flags_ff | set_m) & ~clr_m;
		end
	end

	// Debug control ignores the software reset so a halt setting survives it.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			dbg_ff <= REGC_DBG_RST;
		end else if (a_wr && a_addr == REGC_DBGCTRL_OFS) begin
			dbg_ff <= a_wdata & REGC_DBG_MASK;
		end else if (b_wr && b_addr == REGC_DBGCTRL_OFS) begin
			dbg_ff <= b_wdata & REGC_DBG_MASK;
		end
	end

	// The status field clamps a reserved state code to the top legal code.
	always_comb begin
		nxt_state = hw_state;
		if (hw_state == REGC_STATE_RSVD) begin
			nxt_state = REGC_STATE_TOP;
		end
	end

	// Status follows the hardware only; no write path reaches it.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_ff <= '0;
		end else begin
			status_ff <= '0;
			status_ff[REGC_STAT_STATE_LSB +: 2] <= nxt_state;
			status_ff[REGC_STAT_BUSY_BIT] <= hw_busy;
		end
	end

	// The command bit is write-only and becomes a one-cycle pulse.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_start_ff <= 1'b0;
		end else begin
			cmd_start_ff <= (a_wr && a_addr == REGC_CMD_OFS && a_wdata[REGC_CMD_START_BIT])
				|| (b_wr && b_addr == REGC_CMD_OFS && b_wdata[REGC_CMD_START_BIT]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path.

	// Write-only and unmapped words read as zero, which is safe for any reader.
	always_comb begin
		nxt_rdata = '0;
		case (rd_addr)
			REGC_CTRL_OFS: nxt_rdata = ctrl_ff & REGC_CTRL_MASK;
			REGC_STATUS_OFS: nxt_rdata = status_ff & REGC_STATUS_MASK;
			REGC_CMD_OFS: nxt_rdata = '0;
			REGC_FLAGS_SET_OFS, REGC_FLAGS_CLR_OFS: nxt_rdata[FLAG_W-1:0] = flags_ff;
			REGC_DBGCTRL_OFS: nxt_rdata = dbg_ff & REGC_DBG_MASK;
			default: nxt_rdata = '0;
		endcase
	end

	// Read data is registered, one cycle after the request.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= '0;
			rvalid_ff <= 1'b0;
			rd_addr_ff <= '0;
		end else begin
			rdata_ff <= rd_en ? nxt_rdata : '0;
			rvalid_ff <= rd_en;
			rd_addr_ff <= rd_addr;
		end
	end

	assign rdata = rdata_ff;
	assign rvalid = rvalid_ff;
	assign ctrl_enable = ctrl_ff[REGC_CTRL_EN_BIT];
	assign ctrl_mode = ctrl_ff[REGC_CTRL_MODE_LSB +: 2];
	assign ctrl_cfg = ctrl_ff[REGC_CTRL_CFG_LSB +: 4];
	assign flags = flags_ff;
	assign dbg_halt = dbg_ff[REGC_DBG_HALT_BIT];
	assign cmd_start = cmd_start_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	// A read request followed by its answer one cycle later.
	sequence seq_pair_read;
		rd_en && (rd_addr == REGC_FLAGS_SET_OFS || rd_addr == REGC_FLAGS_CLR_OFS) ##1 rvalid_ff;
	endsequence

	chk_ro_nowrite: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(a_wr && a_addr == REGC_STATUS_OFS && !b_wr && !sw_reset) |=> $stable(ctrl_ff) && $stable(flags_ff)
		&& $stable(dbg_ff) && !cmd_start_ff)
		else $error("Write to status changed other state.");
	chk_wo_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(rd_en && rd_addr == REGC_CMD_OFS) |=> rvalid_ff && rdata_ff == 32'h0000_0000)
		else $error("Command word read back nonzero.");
	chk_wo_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(a_wr && a_addr == REGC_CMD_OFS && a_wdata[0]) |=> cmd_start_ff ##1 !cmd_start_ff || $past(b_wr) || $past(a_wr))
		else $error("Command pulse wrong.");
	chk_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(rvalid_ff && rd_addr_ff == REGC_CTRL_OFS) |-> (rdata_ff & ~REGC_CTRL_MASK) == 32'h0000_0000)
		else $error("Reserved control bits read nonzero.");
	chk_ro_encode: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(rvalid_ff && rd_addr_ff == REGC_STATUS_OFS) |-> rdata_ff[1:0] != REGC_STATE_RSVD)
		else $error("Reserved state code shown.");
	chk_swrst_load: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sw_reset |=> ctrl_ff == REGC_CTRL_RST && flags_ff == '0)
		else $error("Software reset did not load reset values.");
	chk_dbg_keep: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(sw_reset && !(a_wr && a_addr == REGC_DBGCTRL_OFS) && !(b_wr && b_addr == REGC_DBGCTRL_OFS))
		|=> $stable(dbg_ff))
		else $error("Debug control lost on software reset.");
	chk_clr_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(clr_m != '0) |=> (flags_ff & $past(clr_m)) == '0)
		else $error("Clear write left a bit set.");
	chk_set_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(set_m != '0 && !sw_reset) |=> (flags_ff & ($past(set_m) & ~$past(clr_m))) == ($past(set_m) & ~$past(clr_m)))
		else $error("Set write did not set a bit.");
	chk_pair_same: assert property (@(posedge sys_clk) disable iff (!reset_n)
		seq_pair_read |-> rdata_ff[FLAG_W-1:0] == $past(flags_ff))
		else $error("Pair read differs from shared bits.");
	chk_clr_wins: assert property (@(posedge sys_clk) disable iff (!reset_n)
		((set_m & clr_m) != '0) |=> (flags_ff & $past(set_m & clr_m)) == '0)
		else $error("Set beat clear.");
	chk_zero_keep: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!sw_reset |=> ((flags_ff ^ $past(flags_ff)) & ~$past(set_m | clr_m)) == '0)
		else $error("Untouched shared bit changed.");
endmodule

// file: testbench/register_access_conventions_tb.sv
// Self-checking testbench for the generic peripheral register bank.
`timescale 1ns/100ps
module register_access_conventions_tb;
	import regc_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic sw_reset = 1'b0;
	logic a_wr = 1'b0;
	logic b_wr = 1'b0;
	logic rd_en = 1'b0;
	logic hw_busy = 1'b0;
	logic [7:0] a_addr = 8'h00;
	logic [7:0] b_addr = 8'h00;
	logic [7:0] rd_addr = 8'h00;
	logic [31:0] a_wdata = 32'h0000_0000;
	logic [31:0] b_wdata = 32'h0000_0000;
	logic [1:0] hw_state = 2'h0;
	logic [31:0] rdata;
	logic rvalid, ctrl_enable, dbg_halt, cmd_start;
	logic [1:0] ctrl_mode;
	logic [3:0] ctrl_cfg;
	logic [7:0] flags;
	int err_count = 0;
	int n_checks = 0;
	////////////////////////////////////////////////////////////////////////////////
	// The clock toggles every half period of 5 ns.
	always #5 sys_clk = ~sys_clk;
	regc_bank #(.FLAG_W(8)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .sw_reset(sw_reset), .a_wr(a_wr),
		.a_addr(a_addr), .a_wdata(a_wdata), .b_wr(b_wr), .b_addr(b_addr), .b_wdata(b_wdata), .rd_en(rd_en),
		.rd_addr(rd_addr), .hw_state(hw_state), .hw_busy(hw_busy), .rdata(rdata), .rvalid(rvalid),
		.ctrl_enable(ctrl_enable), .ctrl_mode(ctrl_mode), .ctrl_cfg(ctrl_cfg), .flags(flags),
		.dbg_halt(dbg_halt), .cmd_start(cmd_start));
	////////////////////////////////////////////////////////////////////////////////
	// Compares a seen value with the expected one; four-state equality keeps unknowns from passing.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One write cycle on both ports; the strobes drop at the taking edge so the next call starts a cycle later.
	task automatic wr2(input logic aw, input logic [7:0] aa, input logic [31:0] ad,
		input logic bw, input logic [7:0] ba, input logic [31:0] bd);
		@(posedge sys_clk);
		a_wr <= aw;
		a_addr <= aa;
		a_wdata <= ad;
		b_wr <= bw;
		b_addr <= ba;
		b_wdata <= bd;
		@(posedge sys_clk);
		a_wr <= 1'b0;
		b_wr <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [7:0] aa, input logic [31:0] ad);
		wr2(1'b1, aa, ad, 1'b0, 8'h00, 32'h0000_0000);
	endtask
	// The answer shows just after the taking edge, one cycle after the request, and stands for that cycle only.
	task automatic rd(input logic [7:0] ra, input logic [31:0] exp);
		@(posedge sys_clk);
		rd_en <= 1'b1;
		rd_addr <= ra;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		check({31'h0, rvalid}, 32'h0000_0001);
		check(rdata, exp);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Status is read-only: writes must not disturb it, and reserved state 3 must never show.
	task automatic ro_test();
		@(posedge sys_clk);
		hw_state <= 2'h1;
		wr(REGC_STATUS_OFS, 32'hFFFF_FFFF);
		rd(REGC_STATUS_OFS, 32'h0000_0001);
		@(posedge sys_clk);
		hw_state <= 2'h3;
		hw_busy <= 1'b1;
		rd(REGC_STATUS_OFS, 32'h0000_0102);
	endtask
	// The command bit takes a write and pulses, but its read value is the chosen zero.
	task automatic wo_test();
		wr(REGC_CMD_OFS, 32'h0000_0001);
		check({31'h0, cmd_start}, 32'h0000_0001);
		@(posedge sys_clk);
		#1;
		check({31'h0, cmd_start}, 32'h0000_0000);
		rd(REGC_CMD_OFS, 32'h0000_0000);
	endtask
	// Reserved bits read zero; a reserved mode code leaves the old mode in place.
	task automatic rsv_test();
		wr(REGC_CTRL_OFS, 32'hFFFF_FFF5);
		rd(REGC_CTRL_OFS, 32'h0000_00F5);
		wr(REGC_CTRL_OFS, 32'h0000_000C);
		check({30'h0, ctrl_mode}, 32'h0000_0001);
		rd(REGC_CTRL_OFS, 32'h0000_0004);
	endtask
	// Set and clear act on one shared word; clear wins when both hit the same bit at once.
	task automatic setclr_test();
		wr(REGC_FLAGS_SET_OFS, 32'h0000_0005);
		check({24'h00_0000, flags}, 32'h0000_0005);
		rd(REGC_FLAGS_CLR_OFS, 32'h0000_0005);
		wr(REGC_FLAGS_CLR_OFS, 32'h0000_0001);
		rd(REGC_FLAGS_SET_OFS, 32'h0000_0004);
		wr(REGC_FLAGS_SET_OFS, 32'h0000_0000);
		wr(REGC_FLAGS_CLR_OFS, 32'h0000_0000);
		check({24'h00_0000, flags}, 32'h0000_0004);
		wr2(1'b1, REGC_FLAGS_SET_OFS, 32'h0000_000A, 1'b1, REGC_FLAGS_CLR_OFS, 32'h0000_0008);
		check({24'h00_0000, flags}, 32'h0000_0006);
	endtask
	// Software reset clears control and flags but debug control survives until a power reset.
	task automatic reset_test();
		wr(REGC_DBGCTRL_OFS, 32'h0000_0001);
		wr(REGC_CTRL_OFS, 32'h0000_0011);
		check({25'h0, ctrl_cfg, ctrl_mode, ctrl_enable}, 32'h0000_0009);
		wr(REGC_FLAGS_SET_OFS, 32'h0000_00FF);
		check({24'h00_0000, flags}, 32'h0000_00FF);
		@(posedge sys_clk);
		sw_reset <= 1'b1;
		@(posedge sys_clk);
		sw_reset <= 1'b0;
		#1;
		check({17'h0, ctrl_cfg, ctrl_mode, ctrl_enable, flags}, 32'h0000_0000);
		check({31'h0, dbg_halt}, 32'h0000_0001);
		// Flags are loaded again so the power reset has something to clear.
		wr(REGC_FLAGS_SET_OFS, 32'h0000_0030);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		#1;
		check({31'h0, dbg_halt}, 32'h0000_0000);
		check({24'h00_0000, flags}, 32'h0000_0000);
		@(posedge sys_clk);
		reset_n <= 1'b1;
		// A write straight after the release must land, so no edge is lost to the reset.
		wr(REGC_FLAGS_SET_OFS, 32'h0000_0003);
		check({24'h00_0000, flags}, 32'h0000_0003);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset for five cycles, then each scenario in turn.
	initial begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		ro_test();
		wo_test();
		rsv_test();
		setclr_test();
		reset_test();
		give_verdict();
	end
endmodule
